/* pkg/mdb_flash_if.sv */
// carrier between the sequencer and its flash code generator
`timescale 1ns/1ps
`default_nettype none
interface mdb_flash_if;
  logic [2:0] code;
  logic       led;
  modport src (output code, input led);
  modport gen (input code, output led);
endinterface
`default_nettype wire

/* pkg/mdb_pkg.sv */
// constants, types and helpers of the motor dc brake sequencer
// Operation
// - contact closing with function 1..4 starts star-delta, star on
// - after the acceleration delay the delta output comes on
// - functions 1..4 accelerate 20, 15, 10 or 5 seconds in star
// - opening the motor-on contact by stop starts the braking cycle
// - short-circuit variant brakes only once its feedback has closed
// - relay 1 interlocks the motor contactor, open while braking
// - relay 2 drives the star contactor in start and in braking
// - relay 3 is delta in functions 1..4, ready in function 5
// - function 5 leaves star-delta timing to outside logic
// - relay 4 shows standstill, cleared on start or on any fault
// - any detected fault opens every relay output
// - short-circuit variant: interlock, contactor, ready, no standstill
// - braking current follows the current setpoint in amperes
// - braking ends on standstill from phase input or braking current
// - braking ends after 10 seconds without standstill
// - short-circuit variant: the setpoint is a braking time
// - flash codes: 1 frequency, 2 no current, 3 overtemperature
// - flash codes: 4 sync, 5 temp circuit, 6 motor live, 7 contactor
package mdb_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SEC_NS      = 1_000_000_000;
  localparam int SEC_CYC       = T_SEC_NS / CLK_PERIOD_NS;
  localparam int T_MS_NS       = 1_000_000;
  localparam int MS_CYC        = T_MS_NS / CLK_PERIOD_NS;
  // acceleration, brake and contactor times in seconds
  localparam logic [7:0] ACC_FKT1_S   = 8'h14;
  localparam logic [7:0] ACC_FKT2_S   = 8'h0f;
  localparam logic [7:0] ACC_FKT3_S   = 8'h0a;
  localparam logic [7:0] ACC_FKT4_S   = 8'h05;
  localparam logic [7:0] BRAKE_TO_S   = 8'h0a;
  localparam logic [7:0] SC_WAIT_S    = 8'h02;
  // flash timing in milliseconds and debounce in cycles
  localparam int FLASH_ON_MS  = 300;
  localparam int FLASH_OFF_MS = 300;
  localparam int PAUSE_MS     = 1500;
  localparam int FLASH_ON_CYC  = FLASH_ON_MS * MS_CYC;
  localparam int FLASH_OFF_CYC = FLASH_OFF_MS * MS_CYC;
  localparam int PAUSE_CYC     = PAUSE_MS * MS_CYC;
  localparam int DEBOUNCE_CYC  = 1000;
  localparam logic [7:0] SC_CURRENT_A = 8'hff;
  // function switch settings
  localparam logic [2:0] FKT_EXT = 3'h5;
  // fault flash codes
  localparam logic [2:0] FLT_NONE  = 3'h0;
  localparam logic [2:0] FLT_FREQ  = 3'h1;
  localparam logic [2:0] FLT_NOCUR = 3'h2;
  localparam logic [2:0] FLT_OTEMP = 3'h3;
  localparam logic [2:0] FLT_NOSYN = 3'h4;
  localparam logic [2:0] FLT_TCIRC = 3'h5;
  localparam logic [2:0] FLT_MLIVE = 3'h6;
  localparam logic [2:0] FLT_SCSTK = 3'h7;
  // positions in the synchronised pin vector
  localparam int P_MON  = 0;
  localparam int P_SCF  = 1;
  localparam int P_STS  = 2;
  localparam int P_ILOW = 3;
  localparam int P_MV   = 4;
  localparam int P_FLT  = 5;
  localparam int P_VAR  = 10;
  localparam int P_TPC  = 11;
  localparam int P_FKT  = 12;
  localparam int P_ISET = 15;
  localparam int P_TSET = 23;
  localparam int PIN_W  = 31;

  typedef enum logic [2:0] {
    st_idle, st_star, st_run, st_sc_wait, st_brake, st_still, st_fault
  } mdb_state_e;

  // functions 1..4 time the star phase internally
  function automatic logic mdb_internal(input logic [2:0] f);
    return (f >= 3'h1) && (f <= 3'h4);
  endfunction

  // star phase length of a function setting
  function automatic logic [7:0] mdb_acc_s(input logic [2:0] f);
    case (f)
      3'h1:    return ACC_FKT1_S;
      3'h2:    return ACC_FKT2_S;
      3'h3:    return ACC_FKT3_S;
      default: return ACC_FKT4_S;
    endcase
  endfunction
endpackage

/* tb/mdb_motor_model.sv */
// motor, contactors and standstill sensing around the brake sequencer
`timescale 1ns/1ps
`default_nettype none
module mdb_motor_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        brake_on,
  input  wire logic        motor_cmd,
  input  wire logic        use_phase,
  input  wire logic        variant,
  input  wire logic        sc_stuck,
  input  wire logic        welded,
  input  wire logic [15:0] still_dly,
  output logic             standstill_sense_in,
  output logic             brake_current_low_in,
  output logic             shortcircuit_feedback_in,
  output logic             motor_voltage_in
);
  int brk_ff;
  int off_ff;
  // braking age and time since stop; off count saturates to stay small
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brk_ff <= 0;
      off_ff <= 0;
    end else begin
      brk_ff <= brake_on ? brk_ff + 1 : 0;
      off_ff <= motor_cmd ? 0 : off_ff + int'(off_ff < 1000);
    end
  end
  // zero delay means the rotor never stops, forcing the timeout
  wire logic still = (still_dly != 16'h0) && (brk_ff >= int'(still_dly));
  assign standstill_sense_in      = still & use_phase;
  assign brake_current_low_in     = still & ~use_phase;
  // contactor releases 20 cycles after stop unless sc_stuck
  assign shortcircuit_feedback_in = variant & ~sc_stuck &
                                    (off_ff >= 20);
  assign motor_voltage_in         = welded | motor_cmd;
endmodule // mdb_motor_model
`default_nettype wire

/* tb/mdb_top_chk.sv */
// concurrent checks on the brake sequencer ports
`timescale 1ns/1ps
`default_nettype none
module mdb_top_chk import mdb_pkg::*; (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       motor_on_contact_in,
  input wire logic       variant_sc_in,
  input wire logic [2:0] func_sel_in,
  input wire logic       relay_interlock,
  input wire logic       relay_star,
  input wire logic       relay_delta_ready,
  input wire logic       relay_standstill,
  input wire logic       brake_on,
  input wire logic [7:0] brake_current_target,
  input wire logic       error_led,
  input wire logic [2:0] fault_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // decoded helpers shared by several checks
  wire logic       int_fn = (func_sel_in >= 3'h1) && (func_sel_in <= 3'h4);
  wire logic [3:0] relays = {relay_interlock, relay_star,
                             relay_delta_ready, relay_standstill};
  chk_fault_open: assert property (
    fault_code != 3'h0 |=> relays == 4'h0)
    else $error("relay closed in fault");
  chk_led_quiet: assert property (
    fault_code == 3'h0 |-> !error_led)
    else $error("flash without fault");
  chk_brake_lock: assert property (
    brake_on |-> !relay_interlock && relay_star)
    else $error("interlock or star wrong in braking");
  chk_target_idle: assert property (
    !brake_on |-> brake_current_target == 8'h00)
    else $error("current target outside braking");
  chk_sc_current: assert property (
    brake_on && variant_sc_in |->
      brake_current_target == SC_CURRENT_A)
    else $error("variant current target wrong");
  chk_sc_still: assert property (
    variant_sc_in |-> !relay_standstill)
    else $error("standstill relay used in variant");
  chk_still_idle: assert property (
    relay_standstill |-> !brake_on && !relay_star)
    else $error("standstill shown while active");
  chk_star_delta: assert property (
    !variant_sc_in && int_fn && relay_star && !brake_on |->
      !relay_delta_ready)
    else $error("star and delta together");
  chk_delta_after: assert property (
    $rose(relay_delta_ready) && !variant_sc_in && int_fn |->
      $past(relay_star))
    else $error("delta without star phase");
  chk_debounce_stop: assert property (
    $rose(brake_on) && !variant_sc_in |->
      !$past(motor_on_contact_in, 5))
    else $error("braking before contact settled");
endmodule // mdb_top_chk
bind mdb_top mdb_top_chk u_chk (.clk, .nrst, .motor_on_contact_in,
  .variant_sc_in, .func_sel_in, .relay_interlock, .relay_star,
  .relay_delta_ready, .relay_standstill, .brake_on, .brake_current_target,
  .error_led, .fault_code);
`default_nettype wire

/* tb/tb.sv */
// self-checking bench of the brake sequencer with motor model
`timescale 1ns/1ps
`default_nettype none
module tb import mdb_pkg::*;;
  localparam int SEC = 100;
  logic        clk, nrst, mon, var_sc, tpc, stuck, weld;
  logic [2:0]  fsel, fcode;
  logic [4:0]  fsense;
  logic [7:0]  iset, tset, tgt;
  logic [15:0] sdly;
  logic        r_il, r_st, r_dr, r_ss, bon, led;
  wire logic   sts, ilow, scf, mv;
  int          err_count, samples_checked, seed, n, i;

  mdb_top #(.SEC_CYC_P(SEC), .DEBOUNCE_P(4), .FL_ON_P(5), .FL_OFF_P(5),
    .FL_PAUSE_P(20)) u_dut (.clk(clk), .nrst(nrst),
    .motor_on_contact_in(mon), .shortcircuit_feedback_in(scf),
    .standstill_sense_in(sts), .brake_current_low_in(ilow),
    .motor_voltage_in(mv), .fault_sense_in(fsense), .variant_sc_in(var_sc),
    .third_phase_supply_in(tpc), .func_sel_in(fsel),
    .brake_current_setpoint(iset), .brake_time_setpoint(tset),
    .relay_interlock(r_il), .relay_star(r_st), .relay_delta_ready(r_dr),
    .relay_standstill(r_ss), .brake_on(bon), .brake_current_target(tgt),
    .error_led(led), .fault_code(fcode));
  mdb_motor_model u_motor (.clk(clk), .nrst(nrst), .brake_on(bon),
    .motor_cmd(mon), .use_phase(tpc), .variant(var_sc), .sc_stuck(stuck),
    .welded(weld), .still_dly(sdly), .standstill_sense_in(sts),
    .brake_current_low_in(ilow), .shortcircuit_feedback_in(scf),
    .motor_voltage_in(mv));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t mismatch seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  // reset with static straps set while held
  task automatic do_reset(input logic [2:0] f, input logic v);
    nrst = 0;
    fsel = f;
    var_sc = v;
    mon = 0;
    fsense = 0;
    stuck = 0;
    weld = 0;
    tick(4);
    nrst = 1;
    tick(8);
  endtask
  // bounded wait for an output level, c counts cycles
  task automatic wait_for(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 3000) begin
      tick(1);
      c++;
    end
    check(c < 3000, 1);
  endtask
  // flashes in one group, framed by pauses longer than a gap
  task automatic flash_count(output int k);
    int low, t;
    low = 0;
    t = 0;
    k = 0;
    while (low < 12 && t < 600) begin
      tick(1);
      t++;
      low = (led === 1'b1) ? 0 : low + 1;
    end
    low = 1;
    while (low < 12 && t < 1200) begin
      tick(1);
      t++;
      if (led === 1'b1 && low > 0) begin
        k++;
      end
      low = (led === 1'b1) ? 0 : low + 1;
    end
  endtask
  function automatic int acc_cyc(input logic [2:0] f);
    case (f)
      3'h1:    return 20 * SEC;
      3'h2:    return 15 * SEC;
      3'h3:    return 10 * SEC;
      default: return 5 * SEC;
    endcase
  endfunction
  function automatic logic near(input int v, input int e);
    return (v >= e - 3) && (v <= e + 8);
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #500_000;
    err_count++;
    finish_test();
  end

  // scenarios in order; function and variant straps change only while reset is held
  initial begin
    seed = 53;
    err_count = 0;
    samples_checked = 0;
    tpc = 0;
    iset = 8'h00;
    tset = 8'h01;
    sdly = 16'h0;
    // each internal function: glitch, star, delta, brake, standstill
    for (i = 1; i <= 4; i++) begin
      do_reset(i[2:0], 0);
      iset = 8'($random(seed));
      tpc = i[0];
      sdly = 16'(20 + ($random(seed) & 63));
      mon = 1;
      tick(2);
      mon = 0;
      tick(20);
      check(r_st, 0);
      mon = 1;
      wait_for(r_st, 1, n);
      check(r_il, 1);
      wait_for(r_dr, 1, n);
      check(near(n, acc_cyc(i[2:0])), 1);
      check(r_st, 0);
      mon = 0;
      wait_for(bon, 1, n);
      check(tgt, iset);
      check(r_il, 0);
      wait_for(r_ss, 1, n);
      check(near(n, int'(sdly)), 1);
      check({r_il, bon}, 2'b10);
      if (i == 4) begin
        // a fault seen while stopped must clear the standstill relay
        fsense = 5'h10;
        tick(10);
        check(r_ss, 0);
        check(fcode, FLT_TCIRC);
      end else begin
        mon = 1;
        wait_for(r_ss, 0, n);
        check(r_st, 1);
      end
      $display("test function %0d done", i);
    end
    // outside timing, no standstill: timeout ends braking
    do_reset(3'h5, 0);
    check(r_dr, 1);
    mon = 1;
    tick(30);
    check({r_il, r_st, r_dr}, 3'b101);
    sdly = 16'h0;
    mon = 0;
    wait_for(bon, 1, n);
    wait_for(bon, 0, n);
    check(near(n, 10 * SEC), 1);
    tick(2);
    check(r_ss, 0);
    $display("test outside timing done");
    // every sensed fault code, with its flash group
    for (i = 1; i <= 5; i++) begin
      do_reset(3'h4, 0);
      fsense = 5'(1 << (i - 1));
      tick(10);
      check(fcode, i);
      flash_count(n);
      check(n, i);
    end
    // welded motor contactor at stop
    do_reset(3'h4, 0);
    weld = 1;
    mon = 1;
    tick(30);
    mon = 0;
    tick(30);
    check(fcode, FLT_MLIVE);
    check({r_il, r_st, r_dr, r_ss}, 4'h0);
    flash_count(n);
    check(n, 6);
    $display("test faults done");
    // short-circuit variant: feedback gate, timed braking, stuck contactor
    do_reset(3'h1, 1);
    check(r_dr, 1);
    tset = 8'(1 + ($random(seed) & 3));
    mon = 1;
    tick(30);
    mon = 0;
    wait_for(bon, 1, n);
    check(n >= 20, 1);
    wait_for(bon, 0, n);
    check(near(n, int'(tset) * SEC), 1);
    stuck = 1;
    mon = 1;
    tick(30);
    mon = 0;
    tick(2 * SEC + 40);
    check(fcode, FLT_SCSTK);
    $display("test variant done");
    finish_test();
  end
endmodule // tb
`default_nettype wire

/* verilog/mdb_flash.sv */
// flash code generator for the error indicator
`timescale 1ns/1ps
`default_nettype none
module mdb_flash import mdb_pkg::*; #(
  parameter int ON_CYC    = FLASH_ON_CYC,
  parameter int OFF_CYC   = FLASH_OFF_CYC,
  parameter int PAUSE_CYC_P = PAUSE_CYC
) (
  input  wire logic clk,
  input  wire logic nrst,
  mdb_flash_if.gen  fl
);
  logic [31:0] tmr_ff;
  logic [2:0]  left_ff;
  logic        led_ff;
  logic        tmr_done;
  logic        last;

  assign tmr_done = (tmr_ff == 32'h0);
  assign last     = (left_ff == 3'h0);
  assign fl.led   = led_ff;

  // a group of code flashes, then a pause longer than a gap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmr_ff  <= 32'h0;
      left_ff <= 3'h0;
      led_ff  <= 1'b0;
    end else if (fl.code == FLT_NONE) begin
      tmr_ff  <= 32'h0;
      left_ff <= 3'h0;
      led_ff  <= 1'b0;
    end else if (!tmr_done) begin
      tmr_ff <= tmr_ff - 32'h1;
    end else if (led_ff) begin
      led_ff <= 1'b0;
      tmr_ff <= last ? 32'(PAUSE_CYC_P - 1) : 32'(OFF_CYC - 1);
    end else if (last) begin
      left_ff <= fl.code;                  // reload after pause
    end else begin
      led_ff  <= 1'b1;
      left_ff <= left_ff - 3'h1;           // one flash per count
      tmr_ff  <= 32'(ON_CYC - 1);
    end
  end
endmodule // mdb_flash
`default_nettype wire

/* verilog/mdb_top.sv */
// motor dc brake sequencer: inputs, start, braking, relays, faults
`timescale 1ns/1ps
`default_nettype none
module mdb_top import mdb_pkg::*; #(
  parameter int SEC_CYC_P   = SEC_CYC,
  parameter int DEBOUNCE_P  = DEBOUNCE_CYC,
  parameter int FL_ON_P     = FLASH_ON_CYC,
  parameter int FL_OFF_P    = FLASH_OFF_CYC,
  parameter int FL_PAUSE_P  = PAUSE_CYC
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       motor_on_contact_in,
  input  wire logic       shortcircuit_feedback_in,
  input  wire logic       standstill_sense_in,
  input  wire logic       brake_current_low_in,
  input  wire logic       motor_voltage_in,
  input  wire logic [4:0] fault_sense_in,
  input  wire logic       variant_sc_in,
  input  wire logic       third_phase_supply_in,
  input  wire logic [2:0] func_sel_in,
  input  wire logic [7:0] brake_current_setpoint,
  input  wire logic [7:0] brake_time_setpoint,
  output logic            relay_interlock,
  output logic            relay_star,
  output logic            relay_delta_ready,
  output logic            relay_standstill,
  output logic            brake_on,
  output logic      [7:0] brake_current_target,
  output logic            error_led,
  output logic      [2:0] fault_code
);
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] s1_ff;
  logic [PIN_W-1:0] s2_ff;
  logic [PIN_W-1:0] s3_ff;
  logic [PIN_W-1:0] pf_ff;
  logic [1:0]       db_val;
  mdb_state_e       state_ff;
  mdb_state_e       nxt_state;
  logic             mon_q_ff;
  logic [31:0]      pre_ff;
  logic [7:0]       sec_ff;
  logic [2:0]       flt_ff;
  logic [2:0]       nxt_flt;
  logic [2:0]       ext_flt;
  logic [2:0]       fsm_flt;
  logic             intl_ff;
  logic             star_ff;
  logic             r3_ff;
  logic             still_ff;
  logic             brk_ff;
  logic [7:0]       itgt_ff;
  logic             nxt_intl;
  logic             nxt_star;
  logic             nxt_r3;
  logic             nxt_still;
  logic             nxt_brk;
  logic [7:0]       nxt_itgt;

  // gather every outside level into one vector for synchronising
  assign pins = {brake_time_setpoint, brake_current_setpoint, func_sel_in,
                 third_phase_supply_in, variant_sc_in, fault_sense_in,
                 motor_voltage_in, brake_current_low_in,
                 standstill_sense_in, shortcircuit_feedback_in,
                 motor_on_contact_in};

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // agreed value per bit; knobs are static so skew between bits is harmless
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pf_ff <= '0;
    end else begin
      pf_ff <= (s2_ff & s3_ff) | (pf_ff & (s2_ff | s3_ff));
    end
  end

  // named views of the filtered pins
  logic       var_sc;
  logic       tp_conn;
  logic [2:0] fkt;
  logic [7:0] iset;
  logic [7:0] tset;
  logic       ext_mode;
  logic       internal;
  logic       mon;
  logic       scf;
  logic       mon_rise;
  logic       mon_fall;
  logic       standstill;
  logic       tick;
  logic       state_chg;

  assign var_sc   = pf_ff[P_VAR];
  assign tp_conn  = pf_ff[P_TPC];
  assign fkt      = pf_ff[P_FKT +: 3];
  assign iset     = pf_ff[P_ISET +: 8];
  assign tset     = pf_ff[P_TSET +: 8];
  assign internal = mdb_internal(fkt) && !var_sc;
  assign ext_mode = (fkt == FKT_EXT) || var_sc;      // relay 3 as ready
  assign mon      = db_val[0];
  assign scf      = db_val[1];
  assign mon_rise = mon && !mon_q_ff;
  assign mon_fall = !mon && mon_q_ff;

  // contacts must hold a new level for the whole window
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_db
      logic [31:0] cnt_ff;
      logic        val_ff;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cnt_ff <= 32'h0;
          val_ff <= 1'b0;
        end else if (pf_ff[gi] == val_ff) begin
          cnt_ff <= 32'h0;
        end else if (cnt_ff >= 32'(DEBOUNCE_P - 1)) begin
          cnt_ff <= 32'h0;
          val_ff <= pf_ff[gi];
        end else begin
          cnt_ff <= cnt_ff + 32'h1;
        end
      end
      assign db_val[gi] = val_ff;
    end
  endgenerate

  // standstill from the phase input, else from the braking current
  assign standstill = tp_conn ? pf_ff[P_STS] : pf_ff[P_ILOW];

  // seconds count in the current state, restarted on every change
  assign tick      = (pre_ff >= 32'(SEC_CYC_P - 1));
  assign state_chg = (nxt_state != state_ff);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_ff <= 32'h0;
      sec_ff <= 8'h0;
    end else if (state_chg) begin
      pre_ff <= 32'h0;
      sec_ff <= 8'h0;
    end else if (tick) begin
      pre_ff <= 32'h0;
      sec_ff <= (sec_ff == 8'hff) ? sec_ff : sec_ff + 8'h1;
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end

  // outside fault pins, lowest code first
  assign ext_flt = pf_ff[P_FLT]     ? FLT_FREQ  :
                   pf_ff[P_FLT + 1] ? FLT_NOCUR :
                   pf_ff[P_FLT + 2] ? FLT_OTEMP :
                   pf_ff[P_FLT + 3] ? FLT_NOSYN :
                   pf_ff[P_FLT + 4] ? FLT_TCIRC : FLT_NONE;

  // sequence faults found at brake start
  always_comb begin
    fsm_flt = FLT_NONE;
    if ((state_ff == st_star || state_ff == st_run) && mon_fall &&
        !var_sc && pf_ff[P_MV]) begin
      fsm_flt = FLT_MLIVE;
    end else if (state_ff == st_sc_wait && !scf && tick &&
                 sec_ff >= SC_WAIT_S - 8'h1) begin
      fsm_flt = FLT_SCSTK;
    end
  end

  // first fault is held until reset; the flash code does not change
  assign nxt_flt = (flt_ff != FLT_NONE) ? flt_ff :
                   (ext_flt != FLT_NONE) ? ext_flt : fsm_flt;

  // sequencing of start and braking
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle, st_still: begin
        if (mon_rise) begin
          nxt_state = internal ? st_star : st_run;
        end
      end
      st_star: begin
        if (mon_fall) begin
          nxt_state = st_brake;
        end else if (tick && sec_ff >= mdb_acc_s(fkt) - 8'h1) begin
          nxt_state = st_run;
        end
      end
      st_run: begin
        if (mon_fall) begin
          nxt_state = var_sc ? st_sc_wait : st_brake;
        end
      end
      st_sc_wait: begin
        if (scf) begin
          nxt_state = st_brake;
        end
      end
      st_brake: begin
        if (var_sc) begin
          if (tick && sec_ff >= tset - 8'h1) begin
            nxt_state = st_idle;
          end
        end else if (standstill) begin
          nxt_state = st_still;
        end else if (tick && sec_ff >= BRAKE_TO_S - 8'h1) begin
          nxt_state = st_idle;
        end
      end
      st_fault: nxt_state = st_fault;
      default:  nxt_state = st_idle;
    endcase
    if (nxt_flt != FLT_NONE) begin
      nxt_state = st_fault;
    end
  end

  // relay levels derived from the next state
  always_comb begin
    nxt_intl  = 1'b0;
    nxt_star  = 1'b0;
    nxt_r3    = 1'b0;
    nxt_still = 1'b0;
    nxt_brk   = 1'b0;
    nxt_itgt  = 8'h0;
    case (nxt_state)
      st_idle: begin
        nxt_intl = 1'b1;
        nxt_r3   = ext_mode;
      end
      st_still: begin
        nxt_intl  = 1'b1;
        nxt_r3    = ext_mode;
        nxt_still = !var_sc;
      end
      st_star: begin
        nxt_intl = 1'b1;
        nxt_star = 1'b1;
      end
      st_run: begin
        nxt_intl = 1'b1;
        nxt_r3   = internal | ext_mode;              // delta or ready
      end
      st_sc_wait: begin
        nxt_r3 = 1'b1;
      end
      st_brake: begin
        nxt_star = 1'b1;
        nxt_r3   = ext_mode;
        nxt_brk  = 1'b1;
        nxt_itgt = var_sc ? SC_CURRENT_A : iset;
      end
      st_fault: nxt_intl = 1'b0;
      default:  nxt_intl = 1'b0;
    endcase
    // interlock stays open whenever braking current may flow
    if (nxt_brk) begin
      nxt_intl = 1'b0;
    end
  end

  // state, fault and relay registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= st_idle;
      mon_q_ff <= 1'b0;
      flt_ff   <= FLT_NONE;
    end else begin
      state_ff <= nxt_state;
      mon_q_ff <= mon;
      flt_ff   <= nxt_flt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intl_ff  <= 1'b0;
      star_ff  <= 1'b0;
      r3_ff    <= 1'b0;
      still_ff <= 1'b0;
      brk_ff   <= 1'b0;
      itgt_ff  <= 8'h0;
    end else begin
      intl_ff  <= nxt_intl;
      star_ff  <= nxt_star;
      r3_ff    <= nxt_r3;
      still_ff <= nxt_still;
      brk_ff   <= nxt_brk;
      itgt_ff  <= nxt_itgt;
    end
  end

  // fault flash generator
  mdb_flash_if fl_if ();
  assign fl_if.code = flt_ff;

  mdb_flash #(
    .ON_CYC      (FL_ON_P),
    .OFF_CYC     (FL_OFF_P),
    .PAUSE_CYC_P (FL_PAUSE_P)
  ) u_flash (
    .clk  (clk),
    .nrst (nrst),
    .fl   (fl_if.gen)
  );

  assign relay_interlock      = intl_ff;
  assign relay_star           = star_ff;
  assign relay_delta_ready    = r3_ff;
  assign relay_standstill     = still_ff;
  assign brake_on             = brk_ff;
  assign brake_current_target = itgt_ff;
  assign error_led            = fl_if.led;
  assign fault_code           = flt_ff;
endmodule // mdb_top
`default_nettype wire
